//--- hw/irig_b_time_code_receiver.sv
// irig-b dc time code receiver: frame alignment and bcd time of day extraction
`timescale 1ns/10ps
`default_nettype none
module irig_b_time_code_receiver
	import irig_b_pkg::*;
#(
	parameter int unsigned SYMBOL_CYC   = SYM_PERIOD_NS / CLK_PERIOD_NS,
	parameter int unsigned ZERO_ONE_CYC = ZERO_ONE_THR_NS / CLK_PERIOD_NS,
	parameter int unsigned ONE_PI_CYC   = ONE_PI_THR_NS / CLK_PERIOD_NS,
	parameter int unsigned MIN_MARK_CYC = (MIN_MARK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
	parameter int unsigned MAX_MARK_CYC = MAX_MARK_NS / CLK_PERIOD_NS,
	parameter int unsigned TIMEOUT_CYC  = TIMEOUT_NS / CLK_PERIOD_NS
) (
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        irig_i,
	input  wire logic [11:0] host_year_i,
	output time_s            time_o,
	output logic             time_valid_o,
	output logic             sec_boundary_o,
	output logic [CNT_W-1:0] edge_age_o,
	output logic             locked_o,
	output logic             frame_err_o
);

	typedef enum logic [1:0] {
		ST_HUNT     = 2'b00,
		ST_PI_SEEN  = 2'b01,
		ST_IN_FRAME = 2'b11
	} state_e;

	state_e               state_q;
	logic                 sym_valid;
	sym_s                 sym;
	logic [6:0]           pos_q;
	logic [3:0]           digit_q;
	logic [FRAME_LEN-1:0] bits_q;
	logic                 expect_pi;
	logic                 is_pi;
	logic                 misplaced;
	logic                 frame_done;
	logic                 bcd_ok;
	logic [3:0]           year_units;
	logic [3:0]           year_tens;
	logic [11:0]          year_code;
	time_s                time_d;

	// a frame is 100 symbol periods; the symbol period also sizes the default timeout
	localparam int unsigned SYMS_PER_SEC = SYM_PERIOD_NS / CLK_PERIOD_NS * 100 / SYMBOL_CYC;

	irig_symbol_classifier #(
		.ZERO_ONE_CYC (ZERO_ONE_CYC),
		.ONE_PI_CYC   (ONE_PI_CYC),
		.MIN_MARK_CYC (MIN_MARK_CYC),
		.MAX_MARK_CYC (MAX_MARK_CYC),
		.TIMEOUT_CYC  (TIMEOUT_CYC)
	) u_classifier (
		.sys_clk_i   (sys_clk_i),
		.sys_rst_i   (sys_rst_i),
		.line_i      (irig_i),
		.sym_valid_o (sym_valid),
		.sym_o       (sym)
	);

	assign is_pi      = (sym.kind == SYM_PI);
	// an identifier must sit exactly where the position ends in nine
	assign expect_pi  = (digit_q == PI_DIGIT);
	assign misplaced  = (sym.kind == SYM_BAD) || (is_pi != expect_pi);
	assign frame_done = (pos_q == LAST_POS);

	// frame alignment and position tracking
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state_q <= ST_HUNT;
			pos_q   <= '0;
			digit_q <= '0;
		end else if (sym_valid) begin
			case (state_q)
				ST_HUNT: begin
					if (is_pi) begin
						state_q <= ST_PI_SEEN;
					end
				end
				ST_PI_SEEN: begin
					if (is_pi) begin
						// second identifier in a row: this is position 0
						state_q <= ST_IN_FRAME;
						pos_q   <= FIRST_DATA_POS;
						digit_q <= FIRST_DATA_DIGIT;
					end else begin
						state_q <= ST_HUNT;
					end
				end
				ST_IN_FRAME: begin
					if (misplaced) begin
						state_q <= is_pi ? ST_PI_SEEN : ST_HUNT;
					end else if (frame_done) begin
						// the last identifier is the first of the next pair
						state_q <= ST_PI_SEEN;
					end else begin
						pos_q   <= pos_q + 7'h01;
						digit_q <= expect_pi ? 4'h0 : digit_q + 4'h1;
					end
				end
				default: begin
					state_q <= ST_HUNT;
				end
			endcase
		end
	end

	// data symbols are stored at their frame position
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			bits_q <= '0;
		end else if (sym_valid && state_q == ST_IN_FRAME && !is_pi) begin
			bits_q[pos_q] <= (sym.kind == SYM_ONE);
		end
	end

	// bcd fields; every other position is left unread
	always_comb begin
		time_d                = '0;
		time_d.sec_units      = bits_q[POS_SEC_UNITS +: 4];
		time_d.sec_tens       = bits_q[POS_SEC_TENS +: 3];
		time_d.min_units      = bits_q[POS_MIN_UNITS +: 4];
		time_d.min_tens       = bits_q[POS_MIN_TENS +: 3];
		time_d.hour_units     = bits_q[POS_HOUR_UNITS +: 4];
		time_d.hour_tens      = bits_q[POS_HOUR_TENS +: 2];
		time_d.day_units      = bits_q[POS_DAY_UNITS +: 4];
		time_d.day_tens       = bits_q[POS_DAY_TENS +: 4];
		time_d.day_hund       = bits_q[POS_DAY_HUND +: 2];
		time_d.year_from_code = (year_units != 4'h0) || (year_tens != 4'h0);
		time_d.year           = time_d.year_from_code ? year_code : host_year_i;
	end

	// control function bits share the year slots; with options that omit the year
	// the source sends zero there, which falls back to the host year
	assign year_units = bits_q[POS_YEAR_UNITS +: 4];
	assign year_tens  = bits_q[POS_YEAR_TENS +: 4];
	assign year_code  = YEAR_BASE + {8'h00, year_tens} * 12'h00a + {8'h00, year_units};

	// reject frames whose decimal digits cannot be bcd
	assign bcd_ok = (time_d.sec_units <= BCD_MAX) && (time_d.min_units <= BCD_MAX)
		&& (time_d.hour_units <= BCD_MAX) && (time_d.day_units <= BCD_MAX)
		&& (time_d.day_tens <= BCD_MAX) && (year_units <= BCD_MAX)
		&& (year_tens <= BCD_MAX);

	// publish time only for a complete, well formed frame
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			time_o       <= '{default: '0};
			time_valid_o <= 1'b0;
		end else begin
			time_valid_o <= 1'b0;
			if (sym_valid && state_q == ST_IN_FRAME && !misplaced && frame_done && bcd_ok) begin
				time_o       <= time_d;
				time_valid_o <= 1'b1;
			end
		end
	end

	// seconds boundary: mark length tells how long ago the leading edge was
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sec_boundary_o <= 1'b0;
			edge_age_o     <= '0;
		end else begin
			sec_boundary_o <= 1'b0;
			if (sym_valid && state_q == ST_PI_SEEN && is_pi) begin
				sec_boundary_o <= 1'b1;
				edge_age_o     <= sym.mark_cyc;
			end
		end
	end

	// lock follows one clean frame, errors flag a broken one
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			locked_o    <= 1'b0;
			frame_err_o <= 1'b0;
		end else begin
			frame_err_o <= 1'b0;
			if (sym_valid && state_q == ST_IN_FRAME) begin
				if (misplaced || (frame_done && !bcd_ok)) begin
					locked_o    <= 1'b0;
					frame_err_o <= 1'b1;
				end else if (frame_done) begin
					locked_o <= 1'b1;
				end
			end else if (sym_valid && sym.kind == SYM_BAD) begin
				locked_o <= 1'b0;
			end
		end
	end

endmodule : irig_b_time_code_receiver
`default_nettype wire

//--- hw/irig_b_pkg.sv
// constants, symbol and time types for the irig-b time code receiver
package irig_b_pkg;

	// clock and symbol timing, in nanoseconds
	localparam int unsigned CLK_PERIOD_NS    = 4;
	localparam int unsigned SYM_PERIOD_NS    = 10_000_000;
	localparam int unsigned ZERO_MARK_NS     = 2_000_000;
	localparam int unsigned ONE_MARK_NS      = 5_000_000;
	localparam int unsigned PI_MARK_NS       = 8_000_000;
	// thresholds midway between the nominal mark lengths
	localparam int unsigned ZERO_ONE_THR_NS  = (ZERO_MARK_NS + ONE_MARK_NS) / 2;
	localparam int unsigned ONE_PI_THR_NS    = (ONE_MARK_NS + PI_MARK_NS) / 2;
	// marks shorter than half a zero or longer than pi plus a tenth of a symbol period are rejected
	localparam int unsigned MIN_MARK_NS      = ZERO_MARK_NS / 2;
	localparam int unsigned MAX_MARK_NS      = PI_MARK_NS + SYM_PERIOD_NS / 10;
	// a line idle for two symbol periods has lost the code
	localparam int unsigned TIMEOUT_NS       = 2 * SYM_PERIOD_NS;

	localparam int unsigned CNT_W            = 24;

	// frame layout
	localparam int unsigned FRAME_LEN        = 100;
	localparam logic [6:0]  LAST_POS         = 7'h63;
	localparam logic [3:0]  PI_DIGIT         = 4'h9;
	localparam logic [6:0]  FIRST_DATA_POS   = 7'h01;
	localparam logic [3:0]  FIRST_DATA_DIGIT = 4'h1;

	// bcd field positions, lsb first on the line
	localparam int unsigned POS_SEC_UNITS    = 1;
	localparam int unsigned POS_SEC_TENS     = 6;
	localparam int unsigned POS_MIN_UNITS    = 10;
	localparam int unsigned POS_MIN_TENS     = 15;
	localparam int unsigned POS_HOUR_UNITS   = 20;
	localparam int unsigned POS_HOUR_TENS    = 25;
	localparam int unsigned POS_DAY_UNITS    = 30;
	localparam int unsigned POS_DAY_TENS     = 35;
	localparam int unsigned POS_DAY_HUND     = 40;
	localparam int unsigned POS_YEAR_UNITS   = 50;
	localparam int unsigned POS_YEAR_TENS    = 55;

	localparam logic [3:0]  BCD_MAX          = 4'h9;
	localparam logic [11:0] YEAR_BASE        = 12'h7d0;
	localparam logic [11:0] YEAR_RST         = 12'h000;

	typedef enum logic [1:0] {
		SYM_ZERO = 2'b00,
		SYM_ONE  = 2'b01,
		SYM_PI   = 2'b11,
		SYM_BAD  = 2'b10
	} sym_e;

	typedef struct packed {
		sym_e             kind;
		logic [CNT_W-1:0] mark_cyc;
	} sym_s;

	typedef struct packed {
		logic [3:0]  sec_units;
		logic [2:0]  sec_tens;
		logic [3:0]  min_units;
		logic [2:0]  min_tens;
		logic [3:0]  hour_units;
		logic [1:0]  hour_tens;
		logic [3:0]  day_units;
		logic [3:0]  day_tens;
		logic [1:0]  day_hund;
		logic [11:0] year;
		logic        year_from_code;
	} time_s;

endpackage : irig_b_pkg

//--- hw/irig_symbol_classifier.sv
// synchronises the time code line and classifies each symbol by its mark length
`timescale 1ns/10ps
`default_nettype none
module irig_symbol_classifier
	import irig_b_pkg::*;
#(
	parameter int unsigned ZERO_ONE_CYC = 1,
	parameter int unsigned ONE_PI_CYC   = 2,
	parameter int unsigned MIN_MARK_CYC = 1,
	parameter int unsigned MAX_MARK_CYC = 3,
	parameter int unsigned TIMEOUT_CYC  = 4
) (
	input  wire logic sys_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic line_i,
	output logic      sym_valid_o,
	output sym_s      sym_o
);

	logic             line_meta_q;
	logic             line_sync_q;
	logic             line_prev_q;
	logic [CNT_W-1:0] cnt_q;
	logic             rise;
	logic             fall;
	logic             timeout;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			line_meta_q <= 1'b0;
			line_sync_q <= 1'b0;
			line_prev_q <= 1'b0;
		end else begin
			line_meta_q <= line_i;
			line_sync_q <= line_meta_q;
			line_prev_q <= line_sync_q;
		end
	end

	// high is mark, low is space
	assign rise    = line_sync_q & ~line_prev_q;
	assign fall    = ~line_sync_q & line_prev_q;
	assign timeout = (cnt_q == CNT_W'(TIMEOUT_CYC - 1));

	// cycles since the last edge, saturating at the timeout
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			cnt_q <= '0;
		end else if (rise || fall) begin
			cnt_q <= CNT_W'(1);
		end else if (cnt_q != CNT_W'(TIMEOUT_CYC)) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sym_valid_o <= 1'b0;
			sym_o       <= '{kind: SYM_BAD, mark_cyc: '0};
		end else begin
			sym_valid_o <= 1'b0;
			if (fall) begin
				sym_valid_o    <= 1'b1;
				sym_o.mark_cyc <= cnt_q;
				if (cnt_q < CNT_W'(MIN_MARK_CYC) || cnt_q > CNT_W'(MAX_MARK_CYC)) begin
					sym_o.kind <= SYM_BAD;
				end else if (cnt_q < CNT_W'(ZERO_ONE_CYC)) begin
					sym_o.kind <= SYM_ZERO;
				end else if (cnt_q < CNT_W'(ONE_PI_CYC)) begin
					sym_o.kind <= SYM_ONE;
				end else begin
					sym_o.kind <= SYM_PI;
				end
			end else if (timeout && !rise) begin
				// line stuck high or low: report once per stall
				sym_valid_o    <= 1'b1;
				sym_o.kind     <= SYM_BAD;
				sym_o.mark_cyc <= cnt_q;
			end
		end
	end

endmodule : irig_symbol_classifier
`default_nettype wire

//--- tb/irig_b_monitor.sv
// port checker for the irig-b time code receiver
`timescale 1ns/10ps
`default_nettype none
module irig_b_monitor
	import irig_b_pkg::*;
#(
	parameter int unsigned ONE_PI_CYC   = 2,
	parameter int unsigned MAX_MARK_CYC = 3
) (
	input  wire logic             sys_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             irig_i,
	input  wire logic [11:0]      host_year_i,
	input  wire time_s            time_o,
	input  wire logic             time_valid_o,
	input  wire logic             sec_boundary_o,
	input  wire logic [CNT_W-1:0] edge_age_o,
	input  wire logic             locked_o,
	input  wire logic             frame_err_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_valid_pulse: assert property (time_valid_o |=> !time_valid_o)
		else $error("time valid held past one cycle");
	a_bound_edge: assert property (sec_boundary_o |-> $past(irig_i, 6) && !$past(irig_i, 3))
		else $error("boundary without a falling mark");
	a_bound_age: assert property (sec_boundary_o |-> edge_age_o >= ONE_PI_CYC
		&& edge_age_o <= MAX_MARK_CYC)
		else $error("boundary mark length not an identifier");
	a_valid_edge: assert property (time_valid_o |-> $past(irig_i, 6) && !$past(irig_i, 3))
		else $error("publish not at an identifier fall");
	a_valid_locked: assert property (time_valid_o |-> locked_o)
		else $error("publish while unlocked");
	a_err_unlock: assert property (frame_err_o |-> ##[0:1] !locked_o)
		else $error("lock kept after frame error");
	a_time_hold: assert property ($changed(time_o) |-> time_valid_o)
		else $error("time changed without publish");
	a_bcd_digits: assert property (time_valid_o |-> time_o.sec_units <= BCD_MAX
		&& time_o.min_units <= BCD_MAX && time_o.hour_units <= BCD_MAX
		&& time_o.day_units <= BCD_MAX && time_o.day_tens <= BCD_MAX)
		else $error("published digit above nine");
	a_year_src: assert property (time_valid_o |-> (time_o.year_from_code ?
		(time_o.year > YEAR_BASE && time_o.year <= YEAR_BASE + 12'h063) :
		time_o.year == host_year_i))
		else $error("year from wrong source");
endmodule : irig_b_monitor

bind irig_b_time_code_receiver irig_b_monitor #(
	.ONE_PI_CYC  (ONE_PI_CYC),
	.MAX_MARK_CYC(MAX_MARK_CYC)
) u_mon (
	.sys_clk_i     (sys_clk_i),
	.sys_rst_i     (sys_rst_i),
	.irig_i        (irig_i),
	.host_year_i   (host_year_i),
	.time_o        (time_o),
	.time_valid_o  (time_valid_o),
	.sec_boundary_o(sec_boundary_o),
	.edge_age_o    (edge_age_o),
	.locked_o      (locked_o),
	.frame_err_o   (frame_err_o)
);
`default_nettype wire

//--- tb/irig_src_model.sv
// behavioural irig-b dc time code source, 100 cycles per symbol
`timescale 1ns/10ps
`default_nettype none
module irig_src_model (
	input  wire logic sys_clk_i,
	output logic      line_o
);
	initial line_o = 1'b0;

	task send_sym(input int mark);
		@(posedge sys_clk_i);
		#1 line_o = 1'b1;
		repeat (mark) @(posedge sys_clk_i);
		#1 line_o = 1'b0;
		repeat (100 - mark - 1) @(posedge sys_clk_i);
	endtask : send_sym

	// drop names a position sent as its data bit (a zero below position 60, else fill) instead of its identifier
	task send_frame(input logic [7:0] sec, input logic [7:0] min, input logic [7:0] hour,
		input logic [11:0] day, input logic [7:0] year, input int drop, input logic fill);
		logic [99:0] b;
		b = {{40{fill}}, 60'h0};
		b[4:1] = sec[3:0];
		b[8:6] = sec[6:4];
		b[13:10] = min[3:0];
		b[17:15] = min[6:4];
		b[23:20] = hour[3:0];
		b[26:25] = hour[5:4];
		b[33:30] = day[3:0];
		b[38:35] = day[7:4];
		b[41:40] = day[9:8];
		b[53:50] = year[3:0];
		b[58:55] = year[7:4];
		for (int p = 0; p < 100; p++) begin
			if ((p == 0 || p % 10 == 9) && p != drop) send_sym(80);
			else send_sym(b[p] ? 50 : 20);
		end
	endtask : send_frame
endmodule : irig_src_model
`default_nettype wire

//--- tb/irig_b_time_code_receiver_tb_top.sv
// self-checking bench for the irig-b time code receiver
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin fails++; \
	$display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module irig_b_time_code_receiver_tb_top;
	import irig_b_pkg::*;
	logic             sys_clk_i;
	logic             sys_rst_i = 1'b1;
	wire logic        irig_i;
	logic [11:0]      host_year_i = 12'h7e9;
	time_s            time_o;
	logic             time_valid_o;
	logic             sec_boundary_o;
	logic [CNT_W-1:0] edge_age_o;
	logic             locked_o;
	logic             frame_err_o;
	int               fails;
	int               comparisons;
	int               n_valid;
	int               n_bound;
	int               n_err;

	irig_src_model u_src (.sys_clk_i(sys_clk_i), .line_o(irig_i));
	irig_b_time_code_receiver #(.ZERO_ONE_CYC(35), .ONE_PI_CYC(65),
		.MIN_MARK_CYC(10), .MAX_MARK_CYC(90), .TIMEOUT_CYC(200)) u_dut (
		.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .irig_i(irig_i),
		.host_year_i(host_year_i), .time_o(time_o), .time_valid_o(time_valid_o),
		.sec_boundary_o(sec_boundary_o), .edge_age_o(edge_age_o), .locked_o(locked_o),
		.frame_err_o(frame_err_o));

	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i) begin
		n_valid += int'(time_valid_o === 1'b1);
		n_bound += int'(sec_boundary_o === 1'b1);
		n_err += int'(frame_err_o === 1'b1);
	end

	task wrap_up;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	task t_reset;
		repeat (10) @(posedge sys_clk_i);
		#1 sys_rst_i = 1'b0;
		`CHK("locked", 1'b0, locked_o)
		`CHK("time", time_s'(0), time_o)
	endtask : t_reset

	task t_frame_ok(input logic [7:0] s, input logic [7:0] m, input logic [7:0] h,
		input logic [11:0] d, input logic [7:0] y, input logic [11:0] ey, input logic eyc);
		int    v;
		int    b;
		time_s e;
		v = n_valid;
		b = n_bound;
		e = '{s[3:0], s[6:4], m[3:0], m[6:4], h[3:0], h[5:4], d[3:0], d[7:4], d[9:8], ey, eyc};
		u_src.send_frame(s, m, h, d, y, 100, 1'b1);
		`CHK("publish count", v + 1, n_valid)
		`CHK("boundary count", b + 1, n_bound)
		`CHK("edge age", 24'h000050, edge_age_o)
		`CHK("time", e, time_o)
		`CHK("locked", 1'b1, locked_o)
	endtask : t_frame_ok

	task t_bad(input int drop, input logic [7:0] s);
		int v;
		int e;
		v = n_valid;
		e = n_err;
		u_src.send_frame(s, 8'h01, 8'h02, 12'h003, 8'h04, drop, 1'b0);
		`CHK("publish count", v, n_valid)
		`CHK("error count", e + 1, n_err)
		`CHK("locked", 1'b0, locked_o)
	endtask : t_bad

	// identifier at position 0, then a mark too short to be any symbol
	task t_short_mark;
		int e;
		e = n_err;
		u_src.send_sym(80);
		u_src.send_sym(5);
		`CHK("error count", e + 1, n_err)
		`CHK("locked", 1'b0, locked_o)
	endtask : t_short_mark

	initial begin
		#(4 * 70000);
		fails++;
		wrap_up();
	end

	initial begin
		t_reset();
		u_src.send_sym(80);
		t_frame_ok(8'h59, 8'h59, 8'h23, 12'h366, 8'h99, 12'h833, 1'b1);
		// new host year well before the next publish
		#1 host_year_i = 12'h7ea;
		t_frame_ok(8'h00, 8'h00, 8'h00, 12'h001, 8'h00, 12'h7ea, 1'b0);
		t_bad(49, 8'h00);
		t_frame_ok(8'h30, 8'h07, 8'h12, 12'h100, 8'h09, 12'h7d9, 1'b1);
		t_bad(100, 8'h0a);
		t_short_mark();
		wrap_up();
	end
endmodule : irig_b_time_code_receiver_tb_top
`default_nettype wire
